// File: verilog/sebt_cfg.svh
// timing constants for the serial eeprom bus target
// assumes a single system clock; all counts derive from its period
`ifndef SEBT_CFG_SVH
`define SEBT_CFG_SVH

`define SEBT_CLK_PERIOD_NS 100
`define SEBT_GLITCH_FILTER_WIDTH_NS 100
`define SEBT_GLITCH_CYC ((`SEBT_GLITCH_FILTER_WIDTH_NS + `SEBT_CLK_PERIOD_NS - 1) / `SEBT_CLK_PERIOD_NS)
`define SEBT_INTERNAL_PROGRAM_TIME_MS 5
`define SEBT_PROG_CYC ((`SEBT_INTERNAL_PROGRAM_TIME_MS * 1000000) / `SEBT_CLK_PERIOD_NS)
`define SEBT_POWERUP_READY_DELAY_MS 1
`define SEBT_PWRUP_CYC ((`SEBT_POWERUP_READY_DELAY_MS * 1000000) / `SEBT_CLK_PERIOD_NS)

`define SEBT_TYPE_MSB 7
`define SEBT_TYPE_LSB 4
`define SEBT_RSVD_BIT 3
`define SEBT_MEM_ADDR_BIT_NINE 2
`define SEBT_MEM_ADDR_BIT_EIGHT 1
`define SEBT_RW_BIT 0
`define SEBT_BITS_PER_BYTE 8

`endif

// File: verilog/sebt_pkg.sv
// types shared by the bus target and its pin filters
// no constants here; numbers live in sebt_cfg.svh
package sebt_pkg;

   typedef enum logic [7:0] {
      ST_PWRUP  = 8'h01,
      ST_IDLE   = 8'h02,
      ST_RX     = 8'h04,
      ST_ACK    = 8'h08,
      ST_TX     = 8'h10,
      ST_TXACK  = 8'h20,
      ST_IGNORE = 8'h40,
      ST_PROG   = 8'h80
   } sebt_state_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic [1:0] cnt;
      logic rise;
      logic fall;
   } sebt_filt_t;

   typedef struct packed {
      sebt_state_t st;
      logic [7:0] sh;
      logic [3:0] cnt;
      logic [1:0] byte_idx;
      logic rw;
      logic [9:0] addr;
      logic [9:0] wr_addr;
      logic [7:0] wr_data;
      logic wr_stb;
      logic commit;
      logic pend;
      logic wp_lat;
      logic tx_ack;
      logic [7:0] txd;
      logic oe_n;
      logic sda_out;
      logic [15:0] tmr;
      logic ready;
      logic busy;
   } sebt_core_t;

endpackage

// File: verilog/sebt_line_if.sv
// filtered view of one bus line: settled level and edge pulses
// filled by sebt_pin_filter, read by the bus target
`timescale 1ns/1ns
interface sebt_line_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, rise, fall);
   modport dst (input level, rise, fall);
endinterface

// File: verilog/sebt_pin_filter.sv
// synchroniser and glitch filter for one asynchronous pin
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ns
`include "sebt_cfg.svh"
module sebt_pin_filter #(
   parameter logic INIT = 1'b1
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // async reset, active low
   input wire logic pin_i, // raw pin level
   sebt_line_if.src line // filtered level and edges
);
   // two agreeing stages already span one full cycle, so the extra hold is one less;
   // a longer hold pushes the edge delay past half a fast bus clock period
   localparam logic [1:0] GLITCH_CYC = 2'(`SEBT_GLITCH_CYC - 1);
   localparam sebt_pkg::sebt_filt_t RST = '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT,
                                             cnt: 2'h0, rise: 1'b0, fall: 1'b0};

   sebt_pkg::sebt_filt_t r_reg;
   sebt_pkg::sebt_filt_t r_next;

   always_comb
   begin
      r_next = r_reg;
      r_next.s1 = pin_i;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.rise = 1'b0;
      r_next.fall = 1'b0;
      // new level needs agreement of two stages plus a hold beyond the glitch width
      if ((r_reg.s2 == r_reg.s3) && (r_reg.s3 != r_reg.lvl))
      begin
         if (r_reg.cnt >= GLITCH_CYC)
         begin
            r_next.lvl = r_reg.s3;
            r_next.rise = r_reg.s3;
            r_next.fall = ~r_reg.s3;
            r_next.cnt = 2'h0;
         end
         else
         begin
            r_next.cnt = r_reg.cnt + 2'h1;
         end
      end
      else
      begin
         r_next.cnt = 2'h0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         r_reg <= RST;
      else
         r_reg <= r_next;
   end

   assign line.level = r_reg.lvl;
   assign line.rise = r_reg.rise;
   assign line.fall = r_reg.fall;

endmodule // sebt_pin_filter

// File: verilog/sebt_bus_target.sv
// two-wire bus target front end of a small serial eeprom
// assumes an outside controller drives the bus clock; memory array sits outside,
// answering rd_addr_o combinationally on rd_data_i and taking writes by strobe
`timescale 1ns/1ns
`include "sebt_cfg.svh"
module sebt_bus_target #(
   parameter logic [3:0] DEV_TYPE = 4'h5, // arbitrary device-type code
   parameter int PROG_CYC = `SEBT_PROG_CYC, // internal_program_time in cycles
   parameter int PWRUP_CYC = `SEBT_PWRUP_CYC // powerup_ready_delay in cycles
) (
   input wire logic clk_i, // system clock, 10 MHz
   input wire logic rst_n_i, // power-on reset, active low
   input wire logic scl_i, // bus clock pin
   input wire logic sda_i, // bus data pin, input side
   output logic sda_o, // bus data pin, output value (always low)
   output logic sda_oe_n_o, // bus data enable, low pulls line low
   input wire logic wp_i, // write protect pin
   output logic [9:0] rd_addr_o, // current memory address
   input wire logic [7:0] rd_data_i, // memory byte at rd_addr_o
   output logic [9:0] wr_addr_o, // page buffer write address
   output logic [7:0] wr_data_o, // page buffer write data
   output logic wr_stb_o, // page buffer write pulse
   output logic prog_start_o, // pulse: start internal write cycle
   output logic busy_o, // internal write cycle running
   output logic ready_o // standby reached after power-up
);
   localparam logic [15:0] PROG_LAST = 16'(PROG_CYC - 1);
   localparam logic [15:0] PWRUP_LAST = 16'(PWRUP_CYC - 1);
   localparam logic [3:0] BYTE_END = 4'(`SEBT_BITS_PER_BYTE);
   localparam sebt_pkg::sebt_core_t RST = '{
      st: sebt_pkg::ST_PWRUP, sh: 8'h00, cnt: 4'h0, byte_idx: 2'h0, rw: 1'b0,
      addr: 10'h000, wr_addr: 10'h000, wr_data: 8'h00, wr_stb: 1'b0, commit: 1'b0,
      pend: 1'b0, wp_lat: 1'b0, tx_ack: 1'b0, txd: 8'h00, oe_n: 1'b1, sda_out: 1'b0,
      tmr: 16'h0000, ready: 1'b0, busy: 1'b0};

   sebt_line_if scl_l ();
   sebt_line_if sda_l ();
   sebt_line_if wp_l ();

   sebt_pin_filter #(.INIT(1'b1)) u_scl_filt
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(scl_i),
      .line(scl_l)
   );

   sebt_pin_filter #(.INIT(1'b1)) u_sda_filt
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(sda_i),
      .line(sda_l)
   );

   // wp is a plain level but still crosses in from a pin
   sebt_pin_filter #(.INIT(1'b0)) u_wp_filt
   (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(wp_i),
      .line(wp_l)
   );

   sebt_pkg::sebt_core_t r_reg;
   sebt_pkg::sebt_core_t r_next;

   logic start_det;
   logic stop_det;
   logic accept;

   assign start_det = sda_l.fall & scl_l.level;
   assign stop_det = sda_l.rise & scl_l.level;

   always_comb
   begin
      r_next = r_reg;
      accept = 1'b0;
      r_next.wr_stb = 1'b0;
      r_next.commit = 1'b0;
      r_next.sda_out = 1'b0;
      case (r_reg.st)
         sebt_pkg::ST_PWRUP:
         begin
            // bus ignored until the ready delay has run out
            if (r_reg.tmr >= PWRUP_LAST)
            begin
               r_next.st = sebt_pkg::ST_IDLE;
               r_next.tmr = 16'h0000;
            end
            else
            begin
               r_next.tmr = r_reg.tmr + 16'h0001;
            end
         end
         sebt_pkg::ST_IDLE:
         begin
            r_next.oe_n = 1'b1;
         end
         sebt_pkg::ST_RX:
         begin
            if (scl_l.rise && (r_reg.cnt < BYTE_END))
            begin
               r_next.sh = {r_reg.sh[6:0], sda_l.level};
               r_next.cnt = r_reg.cnt + 4'h1;
            end
            if (scl_l.fall && (r_reg.cnt == BYTE_END))
            begin
               case (r_reg.byte_idx)
                  2'h0:
                  begin
                     // reserved bit is not checked
                     if (r_reg.sh[`SEBT_TYPE_MSB:`SEBT_TYPE_LSB] == DEV_TYPE)
                     begin
                        accept = 1'b1;
                        r_next.rw = r_reg.sh[`SEBT_RW_BIT];
                        r_next.addr[9] = r_reg.sh[`SEBT_MEM_ADDR_BIT_NINE];
                        r_next.addr[8] = r_reg.sh[`SEBT_MEM_ADDR_BIT_EIGHT];
                     end
                  end
                  2'h1:
                  begin
                     accept = 1'b1;
                     r_next.addr[7:0] = r_reg.sh;
                  end
                  default:
                  begin
                     if (!r_reg.wp_lat && !wp_l.level)
                     begin
                        accept = 1'b1;
                        r_next.wr_stb = 1'b1;
                        r_next.wr_addr = r_reg.addr;
                        r_next.wr_data = r_reg.sh;
                        r_next.pend = 1'b1;
                        // page wrap: only the low four bits advance
                        r_next.addr[3:0] = r_reg.addr[3:0] + 4'h1;
                     end
                     else
                     begin
                        r_next.pend = 1'b0;
                     end
                  end
               endcase
               if (r_reg.byte_idx != 2'h3)
                  r_next.byte_idx = r_reg.byte_idx + 2'h1;
               if (accept)
               begin
                  r_next.st = sebt_pkg::ST_ACK;
                  r_next.oe_n = 1'b0;
               end
               else
               begin
                  r_next.st = sebt_pkg::ST_IGNORE;
               end
            end
         end
         sebt_pkg::ST_ACK:
         begin
            if (scl_l.fall)
            begin
               // this fall ends the ninth clock of the word address byte
               if (r_reg.byte_idx == 2'h2)
                  r_next.wp_lat = wp_l.level;
               if (r_reg.rw)
               begin
                  r_next.txd = rd_data_i;
                  r_next.oe_n = rd_data_i[7];
                  r_next.cnt = 4'h1;
                  r_next.st = sebt_pkg::ST_TX;
               end
               else
               begin
                  r_next.oe_n = 1'b1;
                  r_next.cnt = 4'h0;
                  r_next.st = sebt_pkg::ST_RX;
               end
            end
         end
         sebt_pkg::ST_TX:
         begin
            if (scl_l.fall)
            begin
               if (r_reg.cnt == BYTE_END)
               begin
                  r_next.oe_n = 1'b1;
                  r_next.addr = r_reg.addr + 10'h001;
                  r_next.st = sebt_pkg::ST_TXACK;
               end
               else
               begin
                  r_next.oe_n = r_reg.txd[6];
                  r_next.txd = {r_reg.txd[6:0], 1'b0};
                  r_next.cnt = r_reg.cnt + 4'h1;
               end
            end
         end
         sebt_pkg::ST_TXACK:
         begin
            if (scl_l.rise)
               r_next.tx_ack = ~sda_l.level;
            if (scl_l.fall)
            begin
               if (r_reg.tx_ack)
               begin
                  r_next.txd = rd_data_i;
                  r_next.oe_n = rd_data_i[7];
                  r_next.cnt = 4'h1;
                  r_next.st = sebt_pkg::ST_TX;
               end
               else
               begin
                  r_next.st = sebt_pkg::ST_IGNORE;
               end
            end
         end
         sebt_pkg::ST_IGNORE:
         begin
            r_next.oe_n = 1'b1;
         end
         sebt_pkg::ST_PROG:
         begin
            // line stays released, so polling controllers see no acknowledge
            r_next.oe_n = 1'b1;
            if (r_reg.tmr >= PROG_LAST)
            begin
               r_next.st = sebt_pkg::ST_IDLE;
               r_next.tmr = 16'h0000;
            end
            else
            begin
               r_next.tmr = r_reg.tmr + 16'h0001;
            end
         end
         default:
         begin
            r_next = RST;
         end
      endcase

      // bus conditions override the byte engine, but not power-up or programming
      if ((r_reg.st != sebt_pkg::ST_PWRUP) && (r_reg.st != sebt_pkg::ST_PROG))
      begin
         if (start_det)
         begin
            r_next.st = sebt_pkg::ST_RX;
            r_next.cnt = 4'h0;
            r_next.byte_idx = 2'h0;
            r_next.oe_n = 1'b1;
            r_next.pend = 1'b0;
            r_next.wp_lat = 1'b0;
         end
         else if (stop_det)
         begin
            r_next.oe_n = 1'b1;
            r_next.pend = 1'b0;
            if (r_reg.pend && !wp_l.level)
            begin
               r_next.st = sebt_pkg::ST_PROG;
               r_next.commit = 1'b1;
               r_next.tmr = 16'h0000;
            end
            else
            begin
               r_next.st = sebt_pkg::ST_IDLE;
            end
         end
      end

      r_next.ready = (r_next.st != sebt_pkg::ST_PWRUP);
      r_next.busy = (r_next.st == sebt_pkg::ST_PROG);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         r_reg <= RST;
      else
         r_reg <= r_next;
   end

   assign sda_o = r_reg.sda_out;
   assign sda_oe_n_o = r_reg.oe_n;
   assign rd_addr_o = r_reg.addr;
   assign wr_addr_o = r_reg.wr_addr;
   assign wr_data_o = r_reg.wr_data;
   assign wr_stb_o = r_reg.wr_stb;
   assign prog_start_o = r_reg.commit;
   assign busy_o = r_reg.busy;
   assign ready_o = r_reg.ready;

endmodule // sebt_bus_target

// File: bench/sebt_properties.sv
// concurrent checks on the bus target, bound to its top module
// assumes one 10 MHz clock domain and an async active-low reset
`timescale 1ns/1ns
module sebt_checker #(
   parameter int PROG_CYC = 50000,
   parameter int PWRUP_CYC = 10000
) (
   input wire logic clk_i, // system clock
   input wire logic rst_n_i, // power-on reset
   input wire logic scl_i, // bus clock pin
   input wire logic wp_i, // write protect pin
   input wire logic sda_o, // data output value
   input wire logic sda_oe_n_o, // data pull enable
   input wire logic wr_stb_o, // page buffer strobe
   input wire logic prog_start_o, // write cycle start
   input wire logic busy_o, // write cycle running
   input wire logic ready_o // power-up done
);
   int up_reg;
   int busy_reg;
   int age_reg;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // up_reg and age_reg saturate so a long run never wraps; busy_reg counts only while busy_o and clears otherwise
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         up_reg <= 0;
         busy_reg <= 0;
         age_reg <= 15;
      end
      else
      begin
         up_reg <= (up_reg < PWRUP_CYC + 8) ? up_reg + 1 : up_reg;
         busy_reg <= busy_o ? busy_reg + 1 : 0;
         // a one-cycle clock pulse is filtered out, so its fall is no reference
         age_reg <= ($fell(scl_i) && $past(scl_i, 2)) ? 0 : ((age_reg < 15) ? age_reg + 1 : 15);
      end
   end
   low_only_a: assert property (sda_o == 1'b0) else $error("data driven high");
   ready_time_a: assert property ($rose(ready_o) |-> up_reg inside {[PWRUP_CYC:PWRUP_CYC + 2]})
      else $error("ready at wrong time");
   ready_late_a: assert property (up_reg == PWRUP_CYC + 8 |-> ready_o) else $error("ready missing");
   early_ack_a: assert property (!ready_o |-> sda_oe_n_o) else $error("answer before ready");
   out_edge_a: assert property ($fell(sda_oe_n_o) |-> age_reg inside {[2:9]})
      else $error("data pulled away from clock fall");
   prog_len_a: assert property ($fell(busy_o) |-> busy_reg inside {[PROG_CYC - 2:PROG_CYC + 2]})
      else $error("write cycle length wrong");
   busy_quiet_a: assert property (busy_o |-> sda_oe_n_o && !wr_stb_o) else $error("active while busy");
   prog_busy_a: assert property (prog_start_o |-> ##[0:1] busy_o) else $error("busy not raised");
   wp_block_a: assert property (wp_i [*8] |-> !wr_stb_o) else $error("write under protect");
   stb_ack_a: assert property (wr_stb_o |-> ##[0:2] !sda_oe_n_o) else $error("accepted byte not acked");
   reset_rel_a: assert property ($rose(rst_n_i) |-> sda_oe_n_o && !ready_o && !busy_o)
      else $error("state kept over reset");
endmodule // sebt_checker
bind sebt_bus_target sebt_checker #(.PROG_CYC(PROG_CYC), .PWRUP_CYC(PWRUP_CYC)) chk_u (.clk_i, .rst_n_i,
   .scl_i, .wp_i, .sda_o, .sda_oe_n_o, .wr_stb_o, .prog_start_o, .busy_o, .ready_o);

// File: bench/sebt_ctl_model.sv
// two-wire bus controller model: drives the bus clock and pulls data low
// assumes a pull-up on the data wire; all changes at clk falling edges
`timescale 1ns/1ns
module sebt_ctl_model (
   input wire logic clk_i, // bench system clock
   input wire logic sda_i, // resolved data wire
   output logic scl_o, // bus clock, push-pull
   output logic sda_low_o // high pulls data low
);
   logic glitch;
   initial
   begin
      scl_o = 1'b1;
      sda_low_o = 1'b0;
      glitch = 1'b0;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk_i);
   endtask
   // 600 ns low, 200 ns high; low phase must outlast the filter delay of the answer
   // 100 ns pulses on both lines when glitch set
   task automatic bit_io(input logic b, output logic r);
      scl_o = 1'b0;
      w(2);
      sda_low_o = !b;
      if (glitch)
      begin
         w(1);
         scl_o = 1'b1;
         w(1);
         scl_o = 1'b0;
         w(2);
      end
      else
         w(4);
      scl_o = 1'b1;
      if (glitch)
      begin
         sda_low_o = !sda_low_o;
         w(1);
         sda_low_o = !sda_low_o;
         w(1);
      end
      else
         w(2);
      r = sda_i;
   endtask
   task automatic start_c;
      scl_o = 1'b0;
      w(2);
      sda_low_o = 1'b0;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_low_o = 1'b1;
      w(4);
   endtask
   task automatic stop_c;
      scl_o = 1'b0;
      w(2);
      sda_low_o = 1'b1;
      w(4);
      scl_o = 1'b1;
      w(4);
      sda_low_o = 1'b0;
      w(4);
   endtask
   // direction bit travels in tx; ninth bit released unless acking a read
   task automatic byte_io(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack_out);
      for (int i = 7; i >= 0; i--)
         bit_io(tx[i], rx[i]);
      bit_io(ack_in, ack_out);
   endtask
endmodule // sebt_ctl_model

// File: bench/sebt_bus_target_bench.sv
// self-checking bench for the bus target with a controller model
// assumes short program and power-up counts; memory modelled here
`timescale 1ns/1ns
module sebt_bus_target_bench;
   localparam int PROG = 200;
   localparam int PWRUP = 20;
   localparam logic [3:0] DT = 4'h5; // arbitrary device-type code
   localparam logic [7:0] AW = {DT, 4'h2};
   localparam logic [7:0] AR = {DT, 4'h3};
   logic clk, rst_n, wp, scl, sda_low, sda_o, oe_n, wr_stb, prog, busy, ready, ak, r;
   logic [9:0] rd_addr, wr_addr, l_addr;
   logic [7:0] rd_data, wr_data, l_data, rx;
   logic [7:0] mem [1024];
   wire sda = (sda_low || !oe_n) ? 1'b0 : 1'b1;
   int err_count = 0, comparisons = 0, stb_n = 0, prog_n = 0, cyc = 0, n;
   assign rd_data = mem[rd_addr];
   sebt_bus_target #(.DEV_TYPE(DT), .PROG_CYC(PROG), .PWRUP_CYC(PWRUP)) dut_u (.clk_i(clk), .rst_n_i(rst_n),
      .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(oe_n), .wp_i(wp), .rd_addr_o(rd_addr),
      .rd_data_i(rd_data), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .wr_stb_o(wr_stb),
      .prog_start_o(prog), .busy_o(busy), .ready_o(ready));
   sebt_ctl_model ctl_u (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk)
   begin
      if (wr_stb === 1'b1)
      begin
         stb_n++;
         l_addr = wr_addr;
         l_data = wr_data;
         mem[wr_addr] = wr_data;
      end
      if (prog === 1'b1)
         prog_n++;
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         $display("BAD %0t run too long", $time);
         test_done();
      end
   end
   task automatic chk(input logic [9:0] g, input logic [9:0] e, input string m);
      comparisons++;
      if (g !== e)
      begin
         err_count++;
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic xb(input logic [7:0] tx, input logic ai, input logic ea);
      ctl_u.byte_io(tx, ai, rx, ak);
      chk({9'h0, ak}, {9'h0, ea}, "ack");
   endtask
   task automatic wait_ready;
      n = 0;
      while (ready !== 1'b1 && n < 100)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic t_power;
      wait_ready();
      chk(n[9:0], 10'(PWRUP), "ready delay");
      $display("power-up test done");
   endtask
   task automatic t_write;
      ctl_u.start_c();
      xb(AW, 1'b1, 1'b0);
      xb(8'h27, 1'b1, 1'b0);
      xb(8'hC3, 1'b1, 1'b0);
      chk(l_addr, 10'h127, "write address");
      chk({2'h0, l_data}, 10'h0C3, "write data");
      ctl_u.stop_c();
      ctl_u.w(4);
      chk(prog_n[9:0], 10'h1, "program start");
      ctl_u.start_c();
      xb(AW, 1'b1, 1'b1);
      ctl_u.stop_c();
      n = 0;
      while (busy !== 1'b0 && n < PROG + 50)
      begin
         @(negedge clk);
         n++;
      end
      chk({9'h0, busy}, 10'h0, "busy end");
      $display("write test done");
   endtask
   task automatic t_wp;
      wp = 1'b1;
      ctl_u.start_c();
      xb(AW, 1'b1, 1'b0);
      xb(8'h28, 1'b1, 1'b0);
      xb(8'h11, 1'b1, 1'b1);
      ctl_u.stop_c();
      ctl_u.w(4);
      chk(stb_n[9:0] + prog_n[9:0], 10'h2, "refused write");
      chk({9'h0, busy}, 10'h0, "no program");
      wp = 1'b0;
      $display("protect test done");
   endtask
   task automatic t_read;
      ctl_u.start_c();
      ctl_u.glitch = 1'b1;
      xb(AW, 1'b1, 1'b0);
      ctl_u.glitch = 1'b0;
      xb(8'h27, 1'b1, 1'b0);
      ctl_u.start_c();
      xb(AR, 1'b1, 1'b0);
      xb(8'hFF, 1'b0, 1'b0);
      chk({2'h0, rx}, 10'h0C3, "read first");
      xb(8'hFF, 1'b1, 1'b1);
      chk({2'h0, rx}, {2'h0, 8'h28 ^ 8'h5A}, "read next");
      ctl_u.stop_c();
      ctl_u.start_c();
      xb({~DT, 4'h2}, 1'b1, 1'b1);
      ctl_u.stop_c();
      $display("read test done");
   endtask
   task automatic t_reset;
      ctl_u.start_c();
      xb(AR, 1'b1, 1'b0);
      ctl_u.bit_io(1'b1, r);
      chk({9'h0, r}, 10'h0, "bit seven");
      rst_n = 1'b0;
      @(negedge clk);
      chk({8'h0, oe_n, ready}, 10'h2, "reset release");
      @(negedge clk);
      rst_n = 1'b1;
      wait_ready();
      ctl_u.stop_c();
      chk({9'h0, ready}, 10'h1, "ready again");
      $display("reset test done");
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial
   begin
      rst_n = 1'b0;
      wp = 1'b0;
      for (int i = 0; i < 1024; i++)
         mem[i] = i[7:0] ^ 8'h5A;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      t_power();
      t_write();
      t_wp();
      t_read();
      t_reset();
      test_done();
   end
endmodule // sebt_bus_target_bench
